// File: codec_power_pkg.sv
// Purpose: Shared constants and types for the codec power/output control
// Assumes: 25 MHz system clock, 12.288 MHz master clock at the codec core
// Notes:   Register offsets are word aligned on a 32-bit APB bus
package codec_power_pkg;

	localparam int CLK_HZ          = 25_000_000;
	localparam int CLK_MHZ         = CLK_HZ / 1_000_000;
	localparam int MASTER_CLOCK_HZ = 12_288_000;

	// Oscillator settling hold-off after power-down release
	localparam int SETTLE_TIME_US  = 28000;
	localparam int SETTLE_CYCLES   = SETTLE_TIME_US * CLK_MHZ;

	// PCM clocking in master mode
	localparam int FRAME_HZ        = 8000;
	localparam int BCLK_COMP_HZ    = 64000;
	localparam int BCLK_LIN_HZ     = 128000;
	localparam int HALF_COMP       = CLK_HZ / (2 * BCLK_COMP_HZ);
	localparam int HALF_LIN        = CLK_HZ / (2 * BCLK_LIN_HZ);
	localparam int BITS_COMP       = BCLK_COMP_HZ / FRAME_HZ;
	localparam int BITS_LIN        = BCLK_LIN_HZ / FRAME_HZ;
	localparam int LONG_SYNC_BITS  = 8;

	// Register map
	localparam logic [7:0] ADDR_CONTROL  = 8'h00;
	localparam logic [7:0] ADDR_ANALOG   = 8'h04;
	localparam logic [7:0] ADDR_PIN_FUNC = 8'h08;
	localparam logic [7:0] ADDR_STATUS   = 8'h0c;

	localparam int CTRL_SOFT_PD    = 7;
	localparam int CTRL_LINE_OFF   = 5;
	localparam int ANA_KEEP        = 7;
	localparam int ANA_ACO_SEL     = 1;
	localparam int ANA_LINE_SEL    = 0;
	localparam int PF_B1           = 1;
	localparam int PF_B2           = 2;

	localparam logic RESET_SOFT_PD  = 1'b0;
	localparam logic RESET_LINE_OFF = 1'b0;
	localparam logic RESET_KEEP     = 1'b0;
	localparam logic RESET_SEL      = 1'b0;
	localparam logic RESET_PF       = 1'b0;

	localparam int ST_PD           = 0;
	localparam int ST_READY        = 1;
	localparam int ST_LINE_OFF     = 2;
	localparam int ST_ACO_SPEECH   = 3;
	localparam int ST_LINE_SPEECH  = 4;
	localparam int ST_SLAVE        = 5;
	localparam int ST_SHORT        = 6;
	localparam int ST_LINEAR       = 7;
	localparam int ST_B1           = 8;
	localparam int ST_B2           = 9;

	// Synchronised pin bundle
	localparam int IN_PD_N         = 0;
	localparam int IN_KEEP         = 1;
	localparam int IN_HOST_SEL     = 2;
	localparam int IN_B1           = 3;
	localparam int IN_B2           = 4;
	localparam int IN_CLK_MODE     = 5;
	localparam int IN_SYNC_SEL     = 6;
	localparam int IN_LINEAR_N     = 7;
	localparam int IN_SYNC         = 8;
	localparam int IN_COUNT        = 9;
	localparam logic [IN_COUNT-1:0] IN_RESET = 9'h000;

	typedef enum logic [1:0] {
		OUT_FLOAT,
		OUT_REFERENCE,
		OUT_SPEECH
	} analog_state_t;

endpackage

// File: pin_synchroniser.sv
// Purpose: Two-flop synchroniser for a bundle of asynchronous pins
// Assumes: Pins are quasi-static relative to the clock
// Notes:   Only the second stage leaves this module
`timescale 1ns/1ps
`default_nettype none
module pin_synchroniser #(
	parameter int                 WIDTH       = 1,
	parameter logic [WIDTH-1:0]   RESET_VALUE = '0
) (
	input  wire logic             clk,    // System clock
	input  wire logic             resetn, // Async reset, active low
	input  wire logic [WIDTH-1:0] pins,   // Raw pin levels
	output logic      [WIDTH-1:0] synced  // Second-stage levels
);

	typedef struct packed {
		logic [WIDTH-1:0] first;
		logic [WIDTH-1:0] second;
	} sync_state_t;

	sync_state_t state_q;
	sync_state_t state_d;

	always_comb begin
		state_d.first  = pins;
		state_d.second = state_q.first;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= {RESET_VALUE, RESET_VALUE};
		end else begin
			state_q <= state_d;
		end
	end

	assign synced = state_q.second;

endmodule
`default_nettype wire

// File: pcm_frame_gen.sv
// Purpose: Bit clock and 8 kHz frame sync for PCM clock master mode
// Assumes: run stays low while the master clock is not settled
// Notes:   Integer divider, so the rates sit a fraction of a percent high
`timescale 1ns/1ps
`default_nettype none
module pcm_frame_gen (
	input  wire logic clk,          // System clock
	input  wire logic resetn,       // Async reset, active low
	input  wire logic run,          // Generate clocks when high
	input  wire logic linearFormat, // 16-bit linear when high
	input  wire logic shortSync,    // Short frame sync when high
	output logic      bitClock,     // Shift clock out
	output logic      frameSync     // Frame sync out
);

	typedef struct packed {
		logic [7:0] halfCnt;
		logic [4:0] bitIdx;
		logic       bitClock;
		logic       frameSync;
	} gen_state_t;

	gen_state_t state_q;
	gen_state_t state_d;
	logic [7:0] halfLast;
	logic [4:0] bitLast;

	always_comb begin
		state_d  = state_q;
		halfLast = linearFormat ? 8'(codec_power_pkg::HALF_LIN - 1)
			: 8'(codec_power_pkg::HALF_COMP - 1);
		bitLast  = linearFormat ? 5'(codec_power_pkg::BITS_LIN - 1)
			: 5'(codec_power_pkg::BITS_COMP - 1);
		if (!run) begin
			state_d = '0;
		end else if (state_q.halfCnt >= halfLast) begin
			state_d.halfCnt  = 8'h00;
			state_d.bitClock = !state_q.bitClock;
			if (!state_q.bitClock) begin
				state_d.bitIdx = (state_q.bitIdx >= bitLast) ? 5'h00
					: state_q.bitIdx + 5'h01;
				// Short sync spans the bit before the frame start
				state_d.frameSync = shortSync
					? (state_d.bitIdx == bitLast)
					: (state_d.bitIdx < 5'(codec_power_pkg::LONG_SYNC_BITS))
						&& (state_d.bitIdx != bitLast);
			end
		end else begin
			state_d.halfCnt = state_q.halfCnt + 8'h01;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign bitClock  = state_q.bitClock;
	assign frameSync = state_q.frameSync;

endmodule
`default_nettype wire

// File: codec_power_output_control.sv
// Purpose: Power-down gating, analog output selection, oscillator settle,
//          secondary pin functions and PCM frame sync for a dual codec
// Assumes: APB slave on a 25 MHz clock; pins are asynchronous
// Notes:   Rules
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module codec_power_output_control #(
	parameter int unsigned ADDR_W        = 8,
	parameter int unsigned SETTLE_CYCLES = codec_power_pkg::SETTLE_CYCLES
) (
	input  wire logic                  clk,             // 25 MHz clock
	input  wire logic                  resetn,          // Async reset
	// APB slave
	input  wire logic                  psel,            // Select
	input  wire logic                  penable,         // Access phase
	input  wire logic                  pwrite,          // Write
	input  wire logic [ADDR_W-1:0]     paddr,           // Byte address
	input  wire logic [31:0]           pwdata,          // Write data
	output logic      [31:0]           prdata,          // Read data
	output logic                       pready,          // Transfer done
	output logic                       pslverr,         // Unmapped
	// Control pins, asynchronous
	input  wire logic                  powerDownPinN,   // Low = power-down
	input  wire logic                  referenceKeepPin, // Keep reference
	input  wire logic                  hostInterfaceSelect, // Host mode
	input  wire logic                  generalInputBOne, // Line disable
	input  wire logic                  generalInputBTwo, // Output select
	input  wire logic                  clockModeSelect, // 1 = slave
	input  wire logic                  frameSyncSelect, // 1 = short
	input  wire logic                  linearFormatN,   // 0 = linear
	input  wire logic                  frameSyncIn,     // Sync in, slave
	// Analog control
	output logic                       acousticAmpOutAOe, // Drive amp A
	output logic                       acousticAmpOutBOe, // Drive amp B
	output logic                       lineAmpOutOe,    // Drive line amp
	output codec_power_pkg::analog_state_t acousticAnalogOut, // State
	output codec_power_pkg::analog_state_t lineAnalogOut,     // State
	output logic                       referenceOn,     // Reference up
	output logic                       lineSideEnable,  // Line codec on
	output logic                       oscillatorRun,   // Crystal drive
	output logic                       masterClockReady, // Clock settled
	// PCM clocks
	output logic                       bitClockOut,     // Bit clock
	output logic                       bitClockOe,      // Drive bit clock
	output logic                       frameSyncOut,    // Frame sync
	output logic                       frameSyncOe      // Drive sync
);

	localparam int SW = $clog2(SETTLE_CYCLES + 1);
	localparam logic [SW-1:0] SETTLE_LOAD = SW'(SETTLE_CYCLES);

	typedef struct packed {
		logic                           softPowerDown;
		logic                           lineDisableBit;
		logic                           keepBit;
		logic                           acousticSelBit;
		logic                           lineSelBit;
		logic                           pinFuncOne;
		logic                           pinFuncTwo;
		logic                           slaveMode;
		logic                           shortSync;
		logic                           linearFormat;
		logic [SW-1:0]                  settleCnt;
		logic                           clockReady;
		logic                           syncPrev;
		logic                           sampledOne;
		logic                           sampledTwo;
		logic                           genRun;
		logic                           ampAOe;
		logic                           ampBOe;
		logic                           lineAmpOe;
		codec_power_pkg::analog_state_t acousticOut;
		codec_power_pkg::analog_state_t lineOut;
		logic                           refOn;
		logic                           lineEnable;
		logic                           oscRun;
		logic                           pcmOe;
		logic [31:0]                    rdata;
		logic                           ready;
		logic                           err;
	} ctl_state_t;

	ctl_state_t                       state_q;
	ctl_state_t                       state_d;
	logic [codec_power_pkg::IN_COUNT-1:0] pinRaw;
	logic [codec_power_pkg::IN_COUNT-1:0] pinSync;
	logic                             genBitClock;
	logic                             genFrameSync;
	logic                             powerDown;
	logic                             secondaryOne;
	logic                             secondaryTwo;
	logic                             lineOff;
	logic                             selectPin;
	logic                             keepAlive;
	logic                             syncNow;
	logic                             syncRise;
	logic                             configOpen;
	logic                             setupPhase;
	logic                             writeNow;
	logic [31:0]                      status;

	// Address decode shared by the read and write paths
	function automatic logic isMapped(input logic [ADDR_W-1:0] a);
		logic [7:0] w;
		w = 8'(a);
		return (w == codec_power_pkg::ADDR_CONTROL)
			|| (w == codec_power_pkg::ADDR_ANALOG)
			|| (w == codec_power_pkg::ADDR_PIN_FUNC)
			|| (w == codec_power_pkg::ADDR_STATUS);
	endfunction

	// Output state of one analog output pin
	function automatic codec_power_pkg::analog_state_t outState(
		input logic pd,
		input logic keep,
		input logic forceRef,
		input logic speech
	);
		codec_power_pkg::analog_state_t r;
		if (pd) begin
			r = keep ? codec_power_pkg::OUT_REFERENCE
				: codec_power_pkg::OUT_FLOAT;
		end else if (forceRef || !speech) begin
			r = codec_power_pkg::OUT_REFERENCE;
		end else begin
			r = codec_power_pkg::OUT_SPEECH;
		end
		return r;
	endfunction

	assign pinRaw = {frameSyncIn, linearFormatN, frameSyncSelect,
		clockModeSelect, generalInputBTwo, generalInputBOne,
		hostInterfaceSelect, referenceKeepPin, powerDownPinN};

	pin_synchroniser #(
		.WIDTH       (codec_power_pkg::IN_COUNT),
		.RESET_VALUE (codec_power_pkg::IN_RESET)
	) u_pin_sync (
		.clk    (clk),
		.resetn (resetn),
		.pins   (pinRaw),
		.synced (pinSync)
	);

	pcm_frame_gen u_frame_gen (
		.clk          (clk),
		.resetn       (resetn),
		.run          (state_q.genRun),
		.linearFormat (state_q.linearFormat),
		.shortSync    (state_q.shortSync),
		.bitClock     (genBitClock),
		.frameSync    (genFrameSync)
	);

	always_comb begin
		state_d = state_q;

		// Either the pin or the soft bit puts the block in power-down
		powerDown = !pinSync[codec_power_pkg::IN_PD_N]
			|| state_q.softPowerDown;
		// Keep-alive only counts while powered down
		keepAlive = powerDown
			&& (pinSync[codec_power_pkg::IN_KEEP] || state_q.keepBit);
		configOpen = powerDown || !state_q.clockReady;

		secondaryOne = pinSync[codec_power_pkg::IN_HOST_SEL]
			|| state_q.pinFuncOne;
		secondaryTwo = pinSync[codec_power_pkg::IN_HOST_SEL]
			|| state_q.pinFuncTwo;

		// Sample on the frame sync seen by the PCM side
		syncNow  = state_q.slaveMode ? pinSync[codec_power_pkg::IN_SYNC]
			: genFrameSync;
		syncRise = syncNow && !state_q.syncPrev;
		state_d.syncPrev = syncNow;
		if (syncRise) begin
			state_d.sampledOne = pinSync[codec_power_pkg::IN_B1];
			state_d.sampledTwo = pinSync[codec_power_pkg::IN_B2];
		end

		// Line disable applied as given; host keeps it steady in a call
		lineOff = state_q.lineDisableBit
			|| (secondaryOne && state_q.sampledOne);
		selectPin = secondaryTwo && state_q.sampledTwo;

		// Clock, sync and format selects only latch in power-down or until the master clock is ready
		if (configOpen) begin
			state_d.slaveMode    = pinSync[codec_power_pkg::IN_CLK_MODE];
			state_d.shortSync    = pinSync[codec_power_pkg::IN_SYNC_SEL];
			state_d.linearFormat = !pinSync[codec_power_pkg::IN_LINEAR_N];
		end

		// Oscillator stops in power-down and must settle after release
		state_d.oscRun = !powerDown;
		if (powerDown) begin
			state_d.settleCnt  = SETTLE_LOAD;
			state_d.clockReady = 1'b0;
		end else if (state_q.settleCnt != '0) begin
			state_d.settleCnt  = state_q.settleCnt - SW'(1);
			state_d.clockReady = 1'b0;
		end else begin
			state_d.clockReady = 1'b1;
		end

		state_d.genRun = !powerDown && state_q.clockReady
			&& !state_q.slaveMode;
		// Pins idle low in master mode and are released in slave mode
		state_d.pcmOe = !state_q.slaveMode;

		state_d.ampAOe     = !powerDown;
		state_d.ampBOe     = !powerDown;
		state_d.lineAmpOe  = !powerDown && !lineOff;
		state_d.lineEnable = !powerDown && !lineOff;
		state_d.refOn      = !powerDown || keepAlive;
		state_d.acousticOut = outState(powerDown, keepAlive, 1'b0,
			selectPin || state_q.acousticSelBit);
		state_d.lineOut = outState(powerDown, keepAlive, lineOff,
			selectPin || state_q.lineSelBit);

		status = 32'h0000_0000;
		status[codec_power_pkg::ST_PD]          = powerDown;
		status[codec_power_pkg::ST_READY]       = state_q.clockReady;
		status[codec_power_pkg::ST_LINE_OFF]    = lineOff;
		status[codec_power_pkg::ST_ACO_SPEECH]  =
			state_q.acousticOut == codec_power_pkg::OUT_SPEECH;
		status[codec_power_pkg::ST_LINE_SPEECH] =
			state_q.lineOut == codec_power_pkg::OUT_SPEECH;
		status[codec_power_pkg::ST_SLAVE]       = state_q.slaveMode;
		status[codec_power_pkg::ST_SHORT]       = state_q.shortSync;
		status[codec_power_pkg::ST_LINEAR]      = state_q.linearFormat;
		status[codec_power_pkg::ST_B1]          = state_q.sampledOne;
		status[codec_power_pkg::ST_B2]          = state_q.sampledTwo;

		// APB: ready rises the cycle after setup, so no wait states
		setupPhase = psel && !penable && !state_q.ready;
		writeNow   = psel && penable && pwrite && state_q.ready
			&& isMapped(paddr);
		state_d.ready = setupPhase;
		state_d.err   = setupPhase && !isMapped(paddr);
		state_d.rdata = 32'h0000_0000;
		if (setupPhase && !pwrite) begin
			case (8'(paddr))
				codec_power_pkg::ADDR_CONTROL: begin
					state_d.rdata[codec_power_pkg::CTRL_SOFT_PD] =
						state_q.softPowerDown;
					state_d.rdata[codec_power_pkg::CTRL_LINE_OFF] =
						state_q.lineDisableBit;
				end
				codec_power_pkg::ADDR_ANALOG: begin
					state_d.rdata[codec_power_pkg::ANA_KEEP] =
						state_q.keepBit;
					state_d.rdata[codec_power_pkg::ANA_ACO_SEL] =
						state_q.acousticSelBit;
					state_d.rdata[codec_power_pkg::ANA_LINE_SEL] =
						state_q.lineSelBit;
				end
				codec_power_pkg::ADDR_PIN_FUNC: begin
					state_d.rdata[codec_power_pkg::PF_B1] =
						state_q.pinFuncOne;
					state_d.rdata[codec_power_pkg::PF_B2] =
						state_q.pinFuncTwo;
				end
				codec_power_pkg::ADDR_STATUS: begin
					state_d.rdata = status;
				end
				default: begin
					state_d.rdata = 32'h0000_0000;
				end
			endcase
		end
		if (writeNow) begin
			case (8'(paddr))
				codec_power_pkg::ADDR_CONTROL: begin
					state_d.softPowerDown =
						pwdata[codec_power_pkg::CTRL_SOFT_PD];
					state_d.lineDisableBit =
						pwdata[codec_power_pkg::CTRL_LINE_OFF];
				end
				codec_power_pkg::ADDR_ANALOG: begin
					state_d.keepBit = pwdata[codec_power_pkg::ANA_KEEP];
					state_d.acousticSelBit =
						pwdata[codec_power_pkg::ANA_ACO_SEL];
					state_d.lineSelBit =
						pwdata[codec_power_pkg::ANA_LINE_SEL];
				end
				codec_power_pkg::ADDR_PIN_FUNC: begin
					state_d.pinFuncOne = pwdata[codec_power_pkg::PF_B1];
					state_d.pinFuncTwo = pwdata[codec_power_pkg::PF_B2];
				end
				default: begin
					state_d.err = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_q               <= '0;
			state_q.softPowerDown <= codec_power_pkg::RESET_SOFT_PD;
			state_q.lineDisableBit <= codec_power_pkg::RESET_LINE_OFF;
			state_q.keepBit       <= codec_power_pkg::RESET_KEEP;
			state_q.acousticSelBit <= codec_power_pkg::RESET_SEL;
			state_q.lineSelBit    <= codec_power_pkg::RESET_SEL;
			state_q.pinFuncOne    <= codec_power_pkg::RESET_PF;
			state_q.pinFuncTwo    <= codec_power_pkg::RESET_PF;
			state_q.settleCnt     <= SETTLE_LOAD;
			state_q.acousticOut   <= codec_power_pkg::OUT_FLOAT;
			state_q.lineOut       <= codec_power_pkg::OUT_FLOAT;
		end else begin
			state_q <= state_d;
		end
	end

	assign prdata            = state_q.rdata;
	assign pready            = state_q.ready;
	assign pslverr           = state_q.err;
	assign acousticAmpOutAOe = state_q.ampAOe;
	assign acousticAmpOutBOe = state_q.ampBOe;
	assign lineAmpOutOe      = state_q.lineAmpOe;
	assign acousticAnalogOut = state_q.acousticOut;
	assign lineAnalogOut     = state_q.lineOut;
	assign referenceOn       = state_q.refOn;
	assign lineSideEnable    = state_q.lineEnable;
	assign oscillatorRun     = state_q.oscRun;
	assign masterClockReady  = state_q.clockReady;
	assign bitClockOut       = genBitClock;
	assign bitClockOe        = state_q.pcmOe;
	assign frameSyncOut      = genFrameSync;
	assign frameSyncOe       = state_q.pcmOe;

endmodule
`default_nettype wire

// File: codec_power_properties.sv
// Purpose: Port-level checks for codec_power_output_control
// Assumes: Pin paths reach the outputs three edges after a change
// Notes:   Bit clock halves are timed by a counter, not by repetition
`timescale 1ns/1ps
`default_nettype none
module codec_power_properties #(
	parameter int unsigned SETTLE_CYCLES = 20
) (
	input wire logic clk, resetn, psel, penable, pready,
	input wire logic powerDownPinN, referenceKeepPin, referenceOn,
	input wire logic acousticAmpOutAOe, acousticAmpOutBOe, lineAmpOutOe,
	input wire codec_power_pkg::analog_state_t acousticAnalogOut,
	input wire codec_power_pkg::analog_state_t lineAnalogOut,
	input wire logic oscillatorRun, masterClockReady, bitClockOut,
	input wire logic frameSyncOut
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence pinDown; !powerDownPinN [*4]; endsequence
	sequence keptDown; (!powerDownPinN && referenceKeepPin) [*4]; endsequence
	logic [31:0] runCnt_q, halfCnt_q;
	logic        bclk_q, seen_q;
	// First toggle after start is skipped: its count runs from before start
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			runCnt_q <= '0;
			halfCnt_q <= '0;
			bclk_q <= 1'b0;
			seen_q <= 1'b0;
		end else begin
			runCnt_q <= oscillatorRun ? runCnt_q + 32'd1 : '0;
			halfCnt_q <= (bitClockOut != bclk_q) ? 32'd1 : halfCnt_q + 32'd1;
			bclk_q <= bitClockOut;
			seen_q <= masterClockReady && (seen_q || bitClockOut != bclk_q);
		end
	end
	a_pd_amp_float: assert property (pinDown |->
		!acousticAmpOutAOe && !acousticAmpOutBOe)
		else $error("Acoustic amp driven in power-down");
	a_pd_line_float: assert property (pinDown |-> !lineAmpOutOe)
		else $error("Line amp driven in power-down");
	a_pd_osc_stop: assert property (pinDown |->
		!oscillatorRun && !masterClockReady)
		else $error("Oscillator running in power-down");
	a_pd_ref_kept: assert property (keptDown |-> referenceOn &&
		acousticAnalogOut == codec_power_pkg::OUT_REFERENCE &&
		lineAnalogOut == codec_power_pkg::OUT_REFERENCE)
		else $error("Reference not kept in power-down");
	a_settle_hold: assert property ($rose(masterClockReady) |->
		runCnt_q >= SETTLE_CYCLES - 1 && runCnt_q <= SETTLE_CYCLES + 2)
		else $error("Clock ready outside settle window");
	a_bclk_half: assert property (bitClockOut != bclk_q && seen_q |->
		halfCnt_q inside {codec_power_pkg::HALF_COMP, codec_power_pkg::HALF_LIN})
		else $error("Bit clock half period wrong");
	a_sync_on_bclk: assert property ($rose(frameSyncOut) |->
		$rose(bitClockOut))
		else $error("Frame sync not on bit clock edge");
	a_apb_ready_pulse: assert property (psel && !penable |=>
		pready ##1 !pready)
		else $error("APB ready not a one-cycle answer");
endmodule
bind codec_power_output_control codec_power_properties #(
	.SETTLE_CYCLES(SETTLE_CYCLES)) u_props (.clk, .resetn, .psel, .penable,
	.pready, .powerDownPinN, .referenceKeepPin, .referenceOn,
	.acousticAmpOutAOe, .acousticAmpOutBOe, .lineAmpOutOe,
	.acousticAnalogOut, .lineAnalogOut, .oscillatorRun,
	.masterClockReady, .bitClockOut, .frameSyncOut);
`default_nettype wire

// File: pcm_sync_partner.sv
// Purpose: Far-side frame sync source for PCM slave mode
// Assumes: The block ignores the bit clock in slave mode
// Notes:   Sync sits low whenever the source is disabled
`timescale 1ns/1ps
`default_nettype none
module pcm_sync_partner (
	input  wire logic clk,       // System clock
	input  wire logic resetn,    // Async reset, active low
	input  wire logic enable,    // Slave mode selected
	input  wire logic shortSync, // Short frame sync when high
	output logic      frameSync  // Sync to the block
);
	localparam int PERIOD = codec_power_pkg::CLK_HZ / codec_power_pkg::FRAME_HZ;
	int unsigned phase;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			phase <= 0;
		else
			phase <= (enable && phase < PERIOD - 1) ? phase + 1 : 0;
	end
	// One 8 kHz frame per PERIOD; long sync spans eight slots
	assign frameSync = enable &&
		(shortSync ? phase == PERIOD - 1 : phase < 8);
endmodule
`default_nettype wire

// File: codec_power_output_control_bench.sv
// Purpose: Self-checking bench for codec_power_output_control
// Assumes: Settle count cut to 20 cycles; pins move only when quiet
// Notes:   Line side and PCM modes are switched only inside power-down
`timescale 1ns/1ps
`default_nettype none
module codec_power_output_control_bench;
	localparam int unsigned SETTLE = 20;
	localparam logic [7:0] CTL = codec_power_pkg::ADDR_CONTROL,
		ANA = codec_power_pkg::ADDR_ANALOG,
		PFN = codec_power_pkg::ADDR_PIN_FUNC, STA = codec_power_pkg::ADDR_STATUS;
	localparam logic [1:0] FLT = codec_power_pkg::OUT_FLOAT,
		REF = codec_power_pkg::OUT_REFERENCE, SPE = codec_power_pkg::OUT_SPEECH;
	logic clk, resetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic powerDownPinN, referenceKeepPin, hostInterfaceSelect;
	logic generalInputBOne, generalInputBTwo, clockModeSelect;
	logic frameSyncSelect, linearFormatN, frameSyncIn, referenceOn;
	logic acousticAmpOutAOe, acousticAmpOutBOe, lineAmpOutOe;
	logic lineSideEnable, oscillatorRun, masterClockReady;
	logic bitClockOut, bitClockOe, frameSyncOut, frameSyncOe;
	logic [4:0] pdVec;
	codec_power_pkg::analog_state_t acousticAnalogOut, lineAnalogOut;
	int err_count = 0, cmp_count = 0, cycles = 0, n;
	assign pdVec = {acousticAmpOutAOe, acousticAmpOutBOe, lineAmpOutOe,
		referenceOn, oscillatorRun};
	codec_power_output_control #(.SETTLE_CYCLES(SETTLE)) u_dut (
		.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .powerDownPinN, .referenceKeepPin,
		.hostInterfaceSelect, .generalInputBOne, .generalInputBTwo,
		.clockModeSelect, .frameSyncSelect, .linearFormatN, .frameSyncIn,
		.acousticAmpOutAOe, .acousticAmpOutBOe, .lineAmpOutOe,
		.acousticAnalogOut, .lineAnalogOut, .referenceOn, .lineSideEnable,
		.oscillatorRun, .masterClockReady, .bitClockOut, .bitClockOe,
		.frameSyncOut, .frameSyncOe);
	pcm_sync_partner u_sync (.clk, .resetn, .enable(clockModeSelect),
		.shortSync(frameSyncSelect), .frameSync(frameSyncIn));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 40000) begin
			err_count++;
			conclude();
		end
	end
	task automatic check(input string name, input logic [31:0] exp, got);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("Error %s: expected %h, seen %h", name, exp, got);
		end
	endtask
	task automatic outs(input logic [1:0] aco, line);
		check("acousticAnalogOut", 32'(aco), 32'(acousticAnalogOut));
		check("lineAnalogOut", 32'(line), 32'(lineAnalogOut));
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		{err, rd} = {pslverr, prdata};
		{psel, penable} <= 2'b00;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check("read data", exp, rd);
	endtask
	task automatic await(ref logic s, input logic v);
		repeat (200) if (s !== v) @(posedge clk);
	endtask
	initial begin
		{resetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{referenceKeepPin, hostInterfaceSelect, generalInputBOne} = '0;
		{generalInputBTwo, clockModeSelect, frameSyncSelect} = '0;
		{powerDownPinN, linearFormatN} = 2'b11;
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		await(masterClockReady, 1'b1);
		rdchk(STA, 32'h2);
		for (int i = 0; i < 3; i++)
			rdchk(8'(4 * i), 32'h0);
		rdchk(8'h10, 32'h0);
		check("pslverr", 32'h1, 32'(err));
		check("bitClockOe", 32'h1, 32'(bitClockOe));
		check("lineSideEnable", 32'h1, 32'(lineSideEnable));
		outs(REF, REF);
		apb(1'b1, ANA, 32'h82);
		repeat (2) @(posedge clk);
		outs(SPE, REF);
		apb(1'b1, ANA, 32'h0);
		apb(1'b1, CTL, 32'ha0);
		repeat (2) @(posedge clk);
		outs(FLT, FLT);
		check("pdVec", 32'h0, 32'(pdVec));
		apb(1'b1, ANA, 32'h80);
		repeat (2) @(posedge clk);
		outs(REF, REF);
		check("referenceOn", 32'h1, 32'(referenceOn));
		apb(1'b1, ANA, 32'h0);
		apb(1'b1, CTL, 32'h20);
		await(masterClockReady, 1'b1);
		apb(1'b1, ANA, 32'h1);
		repeat (2) @(posedge clk);
		outs(REF, REF);
		check("lineSideEnable", 32'h0, 32'(lineSideEnable));
		apb(1'b1, ANA, 32'h0);
		{powerDownPinN, referenceKeepPin, linearFormatN} <= 3'b010;
		apb(1'b1, CTL, 32'h0);
		repeat (6) @(posedge clk);
		check("referenceOn", 32'h1, 32'(referenceOn));
		referenceKeepPin <= 1'b0;
		repeat (6) @(posedge clk);
		check("pdVec", 32'h0, 32'(pdVec));
		powerDownPinN <= 1'b1;
		for (n = 0; n < 200 && masterClockReady !== 1'b1; n++)
			@(posedge clk);
		check("settle", 32'h1, 32'(n >= SETTLE && n <= SETTLE + 8));
		rdchk(STA, 32'h82);
		{hostInterfaceSelect, generalInputBTwo} <= 2'b11;
		repeat (4000) if (acousticAnalogOut !== SPE) @(posedge clk);
		outs(SPE, SPE);
		rdchk(STA, 32'h29a);
		generalInputBTwo <= 1'b0;
		repeat (4000) if (acousticAnalogOut !== REF) @(posedge clk);
		{hostInterfaceSelect, powerDownPinN, generalInputBOne} <= 3'b001;
		{clockModeSelect, frameSyncSelect} <= 2'b11;
		apb(1'b1, PFN, 32'h2);
		repeat (6) @(posedge clk);
		powerDownPinN <= 1'b1;
		await(masterClockReady, 1'b1);
		repeat (3200) @(posedge clk);
		check("lineSideEnable", 32'h0, 32'(lineSideEnable));
		check("pcm oe", 32'h0, 32'({bitClockOe, frameSyncOe}));
		rdchk(STA, 32'h1e6);
		{powerDownPinN, clockModeSelect, generalInputBOne} <= '0;
		repeat (6) @(posedge clk);
		powerDownPinN <= 1'b1;
		await(masterClockReady, 1'b1);
		repeat (3200) @(posedge clk);
		check("lineSideEnable", 32'h1, 32'(lineSideEnable));
		conclude();
	end
endmodule
`default_nettype wire
